// File: rtl/drb_pkg.sv
package drb_pkg;

    // Local clock period and link clock divider
    localparam int CLK_NS     = 20;           // mclk period in ns
    localparam int CK_HALF    = 4;            // mclk cycles per link half period
    localparam int TCK_NS     = 2 * CK_HALF * CLK_NS;

    // Burst geometry in link clocks
    localparam int TCCD_CK    = 4;            // column command spacing
    localparam int BL8_CK     = 4;            // full burst spans four clocks
    localparam int BC4_CK     = 2;            // chopped burst spans two
    localparam int TURN_CK    = 2;            // bus turnaround margin

    // Internal read to precharge delay: larger of 4 clocks or 7.5 ns
    localparam int RTP_MIN_CK = 4;
    localparam int RTP_PS     = 7500;
    localparam int RTP_NS_CK  = (RTP_PS + TCK_NS * 1000 - 1) / (TCK_NS * 1000);
    localparam int RTP_CK     = (RTP_NS_CK > RTP_MIN_CK) ? RTP_NS_CK
                                                          : RTP_MIN_CK;

    // Address pin layout
    localparam int ADDR_W     = 13;           // A0 .. A12
    localparam int COL_W      = 10;           // column bits A0 .. A9
    localparam int AP_POS     = 10;           // auto precharge flag
    localparam int BC_POS     = 12;           // burst length select

    // Mode register 0 burst field codes
    localparam logic [1:0] BF_OTF = 2'h0;     // on the fly
    localparam logic [1:0] BF_FIX = 2'h1;     // per command as well
    localparam logic [1:0] BF_BC4 = 2'h2;     // chop always

    // Reset values
    localparam logic [6:0] SPC_RST = 7'h7F;   // spacing counters start far
    localparam logic [2:0] CK_DIV_RST = 3'h0;

    // Link commands
    typedef enum logic [1:0] {
        DRB_NOP,
        DRB_READ,
        DRB_WRITE,
        DRB_PRE
    } drb_cmd_t;

endpackage : drb_pkg

// File: rtl/drb_link_if.sv
`timescale 1ns/10ps
interface drb_link_if
    import drb_pkg::*;
#(
    parameter int DQ_W = 16
);
    logic              ck;         // Link clock from the controller
    drb_cmd_t          cmd;        // Command, held one full link clock
    logic [ADDR_W-1:0] addr;       // Address pins A0 .. A12
    logic              dqs_o;      // Device strobe drive value
    logic              dqs_oe;     // Device strobe drive enable
    logic [DQ_W-1:0]   dq_o;       // Device data drive value
    logic              dq_oe;      // Device data drive enable
    logic              dqs_line;   // Resolved strobe, low when idle
    logic              dqs_n_line; // Complement half of the strobe
    logic [DQ_W-1:0]   dq_line;    // Resolved data, zero when idle

    // Undriven wires resolve low, as a weak termination would
    assign dqs_line   = dqs_oe & dqs_o;
    assign dqs_n_line = dqs_oe & ~dqs_o;
    assign dq_line    = dq_oe ? dq_o : '0;

    modport dev (
        input  ck, cmd, addr,
        output dqs_o, dqs_oe, dq_o, dq_oe
    );

    modport ctl (
        output ck, cmd, addr,
        input  dqs_line, dqs_n_line, dq_line
    );
endinterface : drb_link_if

// File: rtl/drb_dev.sv
`timescale 1ns/10ps
// Notes on behaviour
// - A12 low chops to four beats, high eight
// - A12 never forms part of column address
// - A12 honoured in on-the-fly and fixed fields
// - Auto precharge does not affect burst length
// - Read latency equals additive plus CAS latency
// - Reads served only while the DLL is locked
// - Strobe drives at RL-1, data at RL
// - Eight-beat read releases pins at RL+4
// - Chopped read releases pins at RL+2
// - Reads four clocks after an eight-beat read stream without gap
// - One-clock gap keeps strobe driven low
// - Write at least six clocks after eight-beat read
// - Write may follow chopped read after four
// - Burst length may switch between adjacent reads
// - Precharge waits additive latency plus read-to-precharge
module drb_dev
    import drb_pkg::*;
#(
    parameter int DQ_W   = 16,        // data pins
    parameter int MAX_RL = 24         // deepest read latency supported
)(
    input  wire logic             mclk,
    input  wire logic             arst_n,
    drb_link_if.dev               lnk,
    input  wire logic [1:0]       mr0_bl,
    input  wire logic [4:0]       al,
    input  wire logic [4:0]       cl,
    input  wire logic             dll_locked,
    output logic                  rd_seen,
    output logic                  wr_seen,
    output logic                  rd_dropped,
    output logic [COL_W-1:0]      cmd_col,
    output logic                  cmd_chop,
    output logic                  cmd_ap
);

    localparam int SCH = MAX_RL + BL8_CK;   // schedule depth in clocks

    // Chop decision from the mode field and A12
    function automatic logic is_chop(input logic [1:0] bf,
                                     input logic       a12);
        if (bf == BF_OTF || bf == BF_FIX) begin
            is_chop = ~a12;
        end else begin
            is_chop = (bf == BF_BC4);
        end
    endfunction : is_chop

    // Beat pattern: column with beat index, sized to the data pins
    function automatic logic [DQ_W-1:0] beat_word(
        input logic [COL_W-1:0] col,
        input logic [2:0]       beat);
        logic [COL_W+2:0] w;
        w = {col, beat};
        beat_word = DQ_W'(w);
    endfunction : beat_word

    // Pin synchronisers; stage two feeds logic, stage three only the link clock edge detect
    logic                    ck_s1_q, ck_s2_q, ck_s3_q;
    drb_cmd_t                cmd_s1_q, cmd_s2_q;
    logic [ADDR_W-1:0]       adr_s1_q, adr_s2_q;

    // Future link clocks, entry 0 is the current one
    logic                    drv_q [SCH];   // strobe driven
    logic                    dat_q [SCH];   // data beats present
    logic [COL_W-1:0]        col_q [SCH];   // column of the burst
    logic [1:0]              bp_q  [SCH];   // beat pair within burst

    logic                    rise_q, fall_q; // Edge pulses delayed a cycle
    logic                    ck_rise, ck_fall;
    logic [5:0]              rl;
    logic                    rd_cmd, rd_ok, chop;
    logic [5:0]              len;

    assign ck_rise = ck_s2_q & ~ck_s3_q;
    assign ck_fall = ~ck_s2_q & ck_s3_q;
    assign rl      = {1'b0, al} + {1'b0, cl};
    assign chop    = is_chop(mr0_bl, adr_s2_q[BC_POS]);
    assign len     = chop ? 6'(BC4_CK) : 6'(BL8_CK);
    assign rd_cmd  = (cmd_s2_q == DRB_READ);
    // Timing is only promised with a locked DLL, so other reads drop.
    // A latency outside 1..MAX_RL has no slot in the schedule either.
    assign rd_ok   = rd_cmd && dll_locked
                     && rl >= 6'h01 && rl <= 6'(MAX_RL);

    // Link clock and command pins cross into mclk
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ck_s1_q  <= 1'b0;
            ck_s2_q  <= 1'b0;
            ck_s3_q  <= 1'b0;
            cmd_s1_q <= DRB_NOP;
            cmd_s2_q <= DRB_NOP;
            adr_s1_q <= '0;
            adr_s2_q <= '0;
        end else begin
            ck_s1_q  <= lnk.ck;
            ck_s2_q  <= ck_s1_q;
            ck_s3_q  <= ck_s2_q;
            cmd_s1_q <= lnk.cmd;
            cmd_s2_q <= cmd_s1_q;
            adr_s1_q <= lnk.addr;
            adr_s2_q <= adr_s1_q;
        end
    end

    // Schedule: shift one clock per rising edge, then add the new read.
    // Drive flags are ORed so a following preamble merges with a tail.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < SCH; i++) begin
                drv_q[i] <= 1'b0;
                dat_q[i] <= 1'b0;
                col_q[i] <= '0;
                bp_q[i]  <= '0;
            end
        end else if (ck_rise) begin
            for (int i = 0; i < SCH; i++) begin
                logic       nd, nt;
                logic [6:0] ii;
                ii = 7'(i);
                nd = (i + 1 < SCH) ? drv_q[(i + 1) % SCH] : 1'b0;
                nt = (i + 1 < SCH) ? dat_q[(i + 1) % SCH] : 1'b0;
                drv_q[i] <= nd;
                dat_q[i] <= nt;
                col_q[i] <= (i + 1 < SCH) ? col_q[(i + 1) % SCH] : '0;
                bp_q[i]  <= (i + 1 < SCH) ? bp_q[(i + 1) % SCH] : '0;
                if (rd_ok) begin
                    // Strobe from RL-1 up to RL+len, data from RL
                    if (ii + 7'h01 >= {1'b0, rl}
                        && ii < {1'b0, rl} + {1'b0, len}) begin
                        drv_q[i] <= 1'b1;
                    end
                    if (ii >= {1'b0, rl}
                        && ii < {1'b0, rl} + {1'b0, len}) begin
                        dat_q[i] <= 1'b1;
                        // Column from A0..A9 only, A12 never used
                        col_q[i] <= adr_s2_q[COL_W-1:0];
                        bp_q[i]  <= 2'(ii - {1'b0, rl});
                    end
                end
            end
        end
    end

    // Edge pulses one cycle late so outputs read the shifted schedule
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            rise_q <= ck_rise;
            fall_q <= ck_fall;
        end
    end

    // Pin drivers: even beat with strobe high after a rise, odd beat
    // with strobe low after a fall; strobe low where no data sits.
    // Outputs trail each link edge by the synchroniser's few mclk.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lnk.dqs_o  <= 1'b0;
            lnk.dqs_oe <= 1'b0;
            lnk.dq_o   <= '0;
            lnk.dq_oe  <= 1'b0;
        end else if (rise_q) begin
            lnk.dqs_oe <= drv_q[0];
            lnk.dq_oe  <= dat_q[0];
            lnk.dqs_o  <= dat_q[0];
            if (dat_q[0]) begin
                lnk.dq_o <= beat_word(col_q[0], {bp_q[0], 1'b0});
            end
        end else if (fall_q) begin
            lnk.dqs_o <= 1'b0;
            if (dat_q[0]) begin
                lnk.dq_o <= beat_word(col_q[0], {bp_q[0], 1'b1});
            end
        end
    end

    // Command reports toward the core
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_seen    <= 1'b0;
            wr_seen    <= 1'b0;
            rd_dropped <= 1'b0;
            cmd_col    <= '0;
            cmd_chop   <= 1'b0;
            cmd_ap     <= 1'b0;
        end else begin
            rd_seen    <= ck_rise && rd_ok;
            wr_seen    <= ck_rise && (cmd_s2_q == DRB_WRITE);
            rd_dropped <= ck_rise && rd_cmd && !rd_ok;
            if (ck_rise && (cmd_s2_q == DRB_READ
                            || cmd_s2_q == DRB_WRITE)) begin
                cmd_col  <= adr_s2_q[COL_W-1:0];
                cmd_chop <= chop;
                cmd_ap   <= adr_s2_q[AP_POS];
            end
        end
    end

endmodule : drb_dev

// File: rtl/drb_ctl.sv
`timescale 1ns/10ps
module drb_ctl
    import drb_pkg::*;
#(
    parameter int DQ_W = 16
)(
    input  wire logic             mclk,
    input  wire logic             arst_n,
    drb_link_if.ctl               lnk,
    input  wire logic [4:0]       al,
    input  wire logic [4:0]       cl,
    input  wire logic [4:0]       cwl,
    input  wire logic             req_valid,
    input  drb_cmd_t              req_kind,
    input  wire logic             req_chop,
    input  wire logic [COL_W-1:0] req_col,
    input  wire logic             req_ap,
    output logic                  req_ready,
    output logic                  rd_valid,
    output logic [DQ_W-1:0]       rd_data
);

    logic [2:0]      div_q;          // Half period counter
    logic            ck_q;           // Link clock made here
    logic            issue;          // Falling edge: command slot
    logic [6:0]      s_col_q;        // Clocks since last read or write
    logic [6:0]      s_rd_q;         // Clocks since last read
    logic            rd_chop_q;      // Last read was chopped
    logic [6:0]      d_col, d_rd;    // Distances at this slot
    logic [6:0]      rl, wl, rd_end, rtp;
    logic            legal;
    logic            dqs_s1_q, dqs_s2_q, dqs_s3_q;
    logic [DQ_W-1:0] dq_s1_q, dq_s2_q;

    assign issue  = ck_q && (div_q == 3'(CK_HALF - 1));
    assign d_col  = (s_col_q == SPC_RST) ? SPC_RST : s_col_q + 7'h01;
    assign d_rd   = (s_rd_q == SPC_RST) ? SPC_RST : s_rd_q + 7'h01;
    assign rl     = {2'h0, al} + {2'h0, cl};
    assign wl     = {2'h0, al} + {2'h0, cwl};
    // Read bus busy until RL plus burst, plus turnaround
    assign rd_end = rl + (rd_chop_q ? 7'(BC4_CK) : 7'(BL8_CK))
                    + 7'(TURN_CK);
    assign rtp    = {2'h0, al} + 7'(RTP_CK);

    // Spacing checks against the last column commands
    always_comb begin
        legal = 1'b1;
        if (req_kind == DRB_READ || req_kind == DRB_WRITE) begin
            legal = d_col >= 7'(TCCD_CK);
        end
        if (req_kind == DRB_WRITE) begin
            // Six clocks after full read, four after chop at RL=WL=5.
            // Widened so a saturated distance plus WL cannot wrap and
            // lock writes out after a long idle spell.
            legal = legal && ({1'b0, d_rd} + {1'b0, wl}
                              >= {1'b0, rd_end});
        end
        if (req_kind == DRB_PRE) begin
            legal = d_rd >= rtp;
        end
    end

    assign req_ready = issue && legal;

    // Divider makes the link clock, one toggle per half period
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= CK_DIV_RST;
            ck_q  <= 1'b0;
        end else if (div_q == 3'(CK_HALF - 1)) begin
            div_q <= CK_DIV_RST;
            ck_q  <= ~ck_q;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    assign lnk.ck = ck_q;

    // Commands change at the falling edge, so the device samples them
    // mid-stable at the next rising edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lnk.cmd  <= DRB_NOP;
            lnk.addr <= '0;
        end else if (issue) begin
            lnk.cmd  <= (req_valid && legal) ? req_kind : DRB_NOP;
            if (req_valid && legal) begin
                lnk.addr <= '0;
                lnk.addr[COL_W-1:0] <= req_col;
                lnk.addr[AP_POS]    <= req_ap;
                lnk.addr[BC_POS]    <= ~req_chop;
            end
        end
    end

    // Spacing counters, one step per link clock
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_col_q   <= SPC_RST;
            s_rd_q    <= SPC_RST;
            rd_chop_q <= 1'b0;
        end else if (issue) begin
            s_col_q <= d_col;
            s_rd_q  <= d_rd;
            if (req_valid && legal && (req_kind == DRB_READ
                                       || req_kind == DRB_WRITE)) begin
                s_col_q <= '0;
            end
            if (req_valid && legal && req_kind == DRB_READ) begin
                s_rd_q    <= '0;
                rd_chop_q <= req_chop;
            end
        end
    end

    // Returned strobe and data cross in; each strobe edge is a beat
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dqs_s1_q <= 1'b0;
            dqs_s2_q <= 1'b0;
            dqs_s3_q <= 1'b0;
            dq_s1_q  <= '0;
            dq_s2_q  <= '0;
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else begin
            // Differential receive: true half high, complement low
            dqs_s1_q <= lnk.dqs_line & ~lnk.dqs_n_line;
            dqs_s2_q <= dqs_s1_q;
            dqs_s3_q <= dqs_s2_q;
            dq_s1_q  <= lnk.dq_line;
            dq_s2_q  <= dq_s1_q;
            rd_valid <= dqs_s2_q ^ dqs_s3_q;
            if (dqs_s2_q ^ dqs_s3_q) begin
                rd_data <= dq_s2_q;
            end
        end
    end

endmodule : drb_ctl

// File: dv/drb_sva.sv
`timescale 1ns/10ps
module drb_sva
    import drb_pkg::*;
(
    input wire logic              mclk,
    input wire logic              arst_n,
    input drb_cmd_t               cmd,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              dqs_o,
    input wire logic              dqs_oe,
    input wire logic              dq_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    logic [7:0] run_q;     // Length of the data drive window in mclk
    logic [6:0] gap_q;     // Mclk since the last column command began
    drb_cmd_t   prev_q;    // Command one mclk earlier
    logic       col_start; // A read or write appears on the pins

    assign col_start = (cmd == DRB_READ || cmd == DRB_WRITE) && cmd != prev_q;

    // Window length; wraps, and a wrap to exactly zero fails the nonzero check
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) run_q <= 8'h00;
        else run_q <= dq_oe ? run_q + 8'h01 : 8'h00;
    end

    // Previous command, to find where a new one starts
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) prev_q <= DRB_NOP;
        else prev_q <= cmd;
    end

    // Saturating distance counter between column commands
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) gap_q <= SPC_RST;
        else if (col_start) gap_q <= 7'h00;
        else if (gap_q != SPC_RST) gap_q <= gap_q + 7'h01;
    end

    property p_preamble;
        $rose(dqs_oe) |-> (!dq_oe && !dqs_o)[*8] ##1 (dq_oe && dqs_o);
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("strobe to data start is not one link clock");

    property p_dq_in_dqs;
        dq_oe |-> dqs_oe;
    endproperty
    a_dq_in_dqs: assert property (p_dq_in_dqs)
        else $error("data driven without the strobe");

    property p_release;
        $fell(dqs_oe) |-> $fell(dq_oe);
    endproperty
    a_release: assert property (p_release)
        else $error("strobe and data not released together");

    property p_burst_len;
        $fell(dq_oe) |-> run_q[3:0] == 4'h0 && run_q != 8'h00;
    endproperty
    a_burst_len: assert property (p_burst_len)
        else $error("data window not a whole number of bursts");

    property p_gap_low;
        $fell(dq_oe) && dqs_oe |-> (dqs_oe && !dqs_o)[*8] ##1 dq_oe;
    endproperty
    a_gap_low: assert property (p_gap_low)
        else $error("strobe not held low through the gap");

    property p_first_beat;
        $rose(dq_oe) |-> dqs_o ##4 (dq_oe && !dqs_o);
    endproperty
    a_first_beat: assert property (p_first_beat)
        else $error("strobe does not toggle each half clock");

    property p_col_space;
        col_start |-> gap_q >= 7'h1F;
    endproperty
    a_col_space: assert property (p_col_space)
        else $error("column commands closer than four clocks");

    property p_cmd_hold;
        $changed(cmd) |=> ($stable(cmd) && $stable(addr))[*7];
    endproperty
    a_cmd_hold: assert property (p_cmd_hold)
        else $error("command or burst select not held a clock");
endmodule : drb_sva

// File: dv/test_ddr3_read_burst_timing.sv
`timescale 1ns/10ps
module test_ddr3_read_burst_timing
    import drb_pkg::*;
;
    logic             mclk, arst_n, dll_locked, req_valid, req_chop, req_ap;
    logic             req_ready, rd_valid, rd_seen, wr_seen, rd_dropped;
    logic             cmd_chop, cmd_ap, prev_oe;
    logic [1:0]       mr0_bl;
    logic [4:0]       al, cl, cwl;
    drb_cmd_t         req_kind, prev_cmd;
    logic [COL_W-1:0] req_col, cmd_col;
    logic [15:0]      rd_data;
    logic [15:0]      got[$], exp_q[$];
    int               t_cmd[$], t_rise[$], runs[$];
    int               failures, cmp_count, tick, run, drops, i;
    int               seen_rd, seen_wr;
    int               seed = 59;

    drb_link_if #(.DQ_W(16)) drb_link_if_i ();
    drb_dev #(.DQ_W(16), .MAX_RL(24)) drb_dev_i (.mclk(mclk), .arst_n(arst_n),
        .lnk(drb_link_if_i), .mr0_bl(mr0_bl), .al(al), .cl(cl),
        .dll_locked(dll_locked), .rd_seen(rd_seen), .wr_seen(wr_seen),
        .rd_dropped(rd_dropped), .cmd_col(cmd_col), .cmd_chop(cmd_chop),
        .cmd_ap(cmd_ap));
    drb_ctl #(.DQ_W(16)) drb_ctl_i (.mclk(mclk), .arst_n(arst_n),
        .lnk(drb_link_if_i), .al(al), .cl(cl), .cwl(cwl),
        .req_valid(req_valid), .req_kind(req_kind), .req_chop(req_chop),
        .req_col(req_col), .req_ap(req_ap), .req_ready(req_ready),
        .rd_valid(rd_valid), .rd_data(rd_data));
    drb_sva drb_sva_i (.mclk(mclk), .arst_n(arst_n),
        .cmd(drb_link_if_i.cmd), .addr(drb_link_if_i.addr),
        .dqs_o(drb_link_if_i.dqs_o), .dqs_oe(drb_link_if_i.dqs_oe),
        .dq_oe(drb_link_if_i.dq_oe));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Records command starts, data window edges and lengths, read beats
    always @(posedge mclk) begin
        tick++;
        if (rd_valid) got.push_back(rd_data);
        if (rd_dropped) drops++;
        if (rd_seen) seen_rd++;
        if (wr_seen) seen_wr++;
        if (drb_link_if_i.cmd != prev_cmd && drb_link_if_i.cmd != DRB_NOP)
            t_cmd.push_back(tick);
        if (drb_link_if_i.dq_oe && !prev_oe) t_rise.push_back(tick);
        if (!drb_link_if_i.dq_oe && prev_oe) runs.push_back(run);
        run = drb_link_if_i.dq_oe ? run + 1 : 0;
        prev_cmd = drb_link_if_i.cmd;
        prev_oe = drb_link_if_i.dq_oe;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
        cmp_count++;
        if (seen !== expd) begin
            failures++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, expd);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // Burst pattern is column in the high bits, beat number below
    function automatic void push_exp(input logic [COL_W-1:0] c,
                                     input logic ch);
        for (int b = 0; b < (ch ? 4 : 8); b++)
            exp_q.push_back({3'h0, c, 3'(b)});
    endfunction : push_exp

    task automatic new_test();
        got.delete();
        exp_q.delete();
        t_cmd.delete();
        t_rise.delete();
        runs.delete();
        drops = 0;
        seen_rd = 0;
        seen_wr = 0;
    endtask : new_test

    // Holds the request until the edge where ready is seen high
    task automatic issue(input drb_cmd_t k, input logic ch,
                         input logic [COL_W-1:0] c, input logic ap);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_kind  <= k;
        req_chop  <= ch;
        req_col   <= c;
        req_ap    <= ap;
        do begin
            @(negedge mclk);
            n++;
        end while (req_ready !== 1'b1 && n < 400);
        @(posedge mclk);
        if (n >= 400) begin
            failures++;
            $display("FAIL %0t request never taken", $time);
        end
    endtask : issue

    // Longest read (RL 24 plus burst) ends well inside 300 mclk
    task automatic finish_test(input string name);
        req_valid <= 1'b0;
        repeat (300) @(posedge mclk);
        chk(got.size(), exp_q.size());
        foreach (exp_q[j]) chk(got[j], exp_q[j]);
        $display("done %s", name);
    endtask : finish_test

    task automatic one_read(input logic [1:0] bl, input logic [4:0] a,
                            input logic [4:0] c, input logic ch);
        logic [COL_W-1:0] col;
        logic             ap;
        logic             eff;
        col = COL_W'($random(seed));
        ap  = 1'($random(seed));
        eff = (bl == BF_BC4) ? 1'b1 : (bl == 2'h3) ? 1'b0 : ch;
        new_test();
        mr0_bl <= bl;
        al     <= a;
        cl     <= c;
        issue(DRB_READ, ch, col, ap);
        push_exp(col, eff);
        finish_test("single read");
        chk(cmd_col, col);
        chk(cmd_chop, eff);
        chk(cmd_ap, ap);
        chk((t_rise[0] - t_cmd[0] - 4) / 8, a + c);
        chk(runs[0], eff ? 16 : 32);
        chk(seen_rd, 1);
    endtask : one_read

    // Read then a second command, optionally delayed by gap mclk
    task automatic pair(input drb_cmd_t k2, input logic c1, input logic c2,
                        input int gap, input int a, input int sp);
        logic [COL_W-1:0] c;
        c = COL_W'($random(seed));
        new_test();
        mr0_bl <= BF_OTF;
        al     <= 5'(a);
        cl     <= 5'h05;
        issue(DRB_READ, c1, c, 1'b0);
        push_exp(c, c1);
        if (gap > 0) begin
            req_valid <= 1'b0;
            repeat (gap) @(posedge mclk);
        end
        issue(k2, c2, COL_W'(c + 1), 1'b0);
        if (k2 == DRB_READ) push_exp(COL_W'(c + 1), c2);
        finish_test("pair");
        chk((t_cmd[1] - t_cmd[0]) / 8, sp);
        chk(seen_rd, (k2 == DRB_READ) ? 2 : 1);
        chk(seen_wr, k2 == DRB_WRITE);
        // A chopped first burst releases the data pins for two clocks
        if (k2 == DRB_READ && gap == 0)
            chk(runs[0], c1 ? 16 : 32 + (c2 ? 16 : 32));
        if (k2 == DRB_READ && gap == 0 && c1)
            chk(runs[1], c2 ? 16 : 32);
    endtask : pair

    initial begin
        repeat (30000) @(posedge mclk);
        failures++;
        $display("FAIL %0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        arst_n = 1'b0;
        dll_locked = 1'b1;
        req_valid = 1'b0;
        req_kind = DRB_NOP;
        req_chop = 1'b0;
        req_col = '0;
        req_ap = 1'b0;
        mr0_bl = BF_OTF;
        al = 5'h00;
        cl = 5'h05;
        cwl = 5'h05;
        prev_oe = 1'b0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        // A write with no read behind it must not be held off
        new_test();
        issue(DRB_WRITE, 1'b0, 10'h0AA, 1'b0);
        finish_test("idle write");
        chk(seen_wr, 1);
        one_read(BF_OTF, 5'h00, 5'h05, 1'b0);
        one_read(BF_OTF, 5'h04, 5'h05, 1'b1);
        for (i = 0; i < 4; i++) one_read(2'(i), 5'h02, 5'h06, 1'(i));
        repeat (6) one_read(BF_OTF, 5'($unsigned($random(seed)) % 13),
            5'($unsigned($random(seed)) % 7 + 5), 1'($random(seed)));
        pair(DRB_READ, 1'b0, 1'b0, 0, 0, 4);
        pair(DRB_READ, 1'b1, 1'b1, 0, 0, 4);
        pair(DRB_READ, 1'b0, 1'b1, 0, 0, 4);
        pair(DRB_READ, 1'b0, 1'b0, 33, 0, 5);
        pair(DRB_WRITE, 1'b0, 1'b0, 0, 0, 6);
        pair(DRB_WRITE, 1'b1, 1'b1, 0, 0, 4);
        pair(DRB_PRE, 1'b0, 1'b0, 0, 4, 4 + RTP_CK);
        new_test();
        dll_locked <= 1'b0;
        issue(DRB_READ, 1'b0, 10'h155, 1'b0);
        finish_test("unlocked read");
        chk(drops, 1);
        chk(runs.size(), 0);
        chk(seen_rd, 0);
        report_and_stop();
    end
endmodule : test_ddr3_read_burst_timing
